// ---- inc/sdst_pkg.sv ----
// What this block does
// - Ratio test feeds the converter reference in both integrate and read phases.
// - Ratio test ends on a new continuity press or on power removal.
// - Relative held through power-up, then released, starts the switch-decoding test.
// - Switch-decoding test lasts until power removal; no button ends it.
// - Digit zero shows range code 0 to 4, 0 when no range switch.
// - Digit one shows buttons as weights: relative 1, continuity 2, decibel 4, frequency 8.
// - Digit three shows function code 2 to 7; ac voltage shows a dash.
// - Range switches are scanned from the highest down; code 0 is the fallback.
// - The lowest pressed range switch wins over any higher one.
// - The 2 kilohm switch with the 20 kilohm switch selects diode test.
// - The 200 kilohm switch with the megohm switch selects conductance unless a lower range switch is pressed.
// - In switch-decoding test the continuity bar follows the comparator.
package sdst_pkg;

    // Operating modes
    typedef enum logic [2:0] {
        SDST_POWERUP = 3'b000,
        SDST_NORMAL = 3'b001,
        SDST_HOLD_RATIO = 3'b010,
        SDST_RATIO = 3'b011,
        SDST_HOLD_DECODE = 3'b100,
        SDST_DECODE = 3'b101
    } sdst_mode_t;

    // Function selector pins
    typedef struct packed {
        logic ac_volt;
        logic dc_volt;
        logic ac_curr;
        logic dc_curr;
        logic ohms;
    } sdst_func_sel_t;

    // Push buttons, packed so that the vector is the digit-one weight
    typedef struct packed {
        logic freq;
        logic decibel;
        logic continuity;
        logic relative;
    } sdst_btn_t;

    // Converter input routing
    typedef struct packed {
        logic integ_src_ref;
        logic read_src_ref;
    } sdst_conv_t;

    // Display outputs
    typedef struct packed {
        logic show_decode;
        logic [3:0] digit0;
        logic [3:0] digit1;
        logic [3:0] digit3;
        logic digit3_dash;
        logic cont_bar;
    } sdst_disp_t;

    localparam int SDST_NUM_RANGE_SW = 4;
    localparam int SDST_SYNC_W = 14;

    // Range switch positions in the scan vector
    localparam int SDST_SW_2K = 0;
    localparam int SDST_SW_20K = 1;
    localparam int SDST_SW_200K = 2;
    localparam int SDST_SW_MEG = 3;

    // Range codes
    localparam logic [3:0] SDST_RANGE_DEFAULT = 4'h0;

    // Function codes
    localparam logic [3:0] SDST_FN_NONE = 4'h0;
    localparam logic [3:0] SDST_FN_DC_VOLT = 4'h2;
    localparam logic [3:0] SDST_FN_AC_CURR = 4'h3;
    localparam logic [3:0] SDST_FN_DC_CURR = 4'h4;
    localparam logic [3:0] SDST_FN_OHMS = 4'h5;
    localparam logic [3:0] SDST_FN_COND = 4'h6;
    localparam logic [3:0] SDST_FN_DIODE = 4'h7;

    // Reset values and the ratio-test routing
    localparam sdst_conv_t SDST_CONV_NORMAL = '{integ_src_ref: 1'b0, read_src_ref: 1'b1};
    localparam sdst_conv_t SDST_CONV_RATIO = '{integ_src_ref: 1'b1, read_src_ref: 1'b1};
    localparam sdst_disp_t SDST_DISP_RESET = '0;

endpackage : sdst_pkg

// ---- verilog/sdst_sync.sv ----
`timescale 1ns/1ps
module sdst_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Pin side and synchronised side
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta;

    // Two-stage synchroniser; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    meta[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else if (clk_en) begin
                    meta[i] <= pin_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule : sdst_sync

// ---- verilog/sdst_top.sv ----
`timescale 1ns/1ps
module sdst_top (
    // Clock, power-on reset and freeze
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Power-on all-segments pattern finished (same clock domain)
    input wire logic pattern_done,
    // Front-panel pins
    input wire sdst_pkg::sdst_func_sel_t func_sel,
    input wire sdst_pkg::sdst_btn_t buttons,
    input wire logic [3:0] range_sw,
    input wire logic comparator_minus_below_plus,
    // Converter routing
    output sdst_pkg::sdst_conv_t conv_ctl,
    // Display
    output sdst_pkg::sdst_disp_t disp,
    output sdst_pkg::sdst_mode_t mode
);

    sdst_pkg::sdst_func_sel_t fn_s;
    sdst_pkg::sdst_btn_t btn_s;
    logic [3:0] range_s;
    logic cmp_s;
    logic cont_q;
    logic cont_rise;
    logic vi_sel;
    sdst_pkg::sdst_mode_t next_mode;

    // Range scan: lowest pressed switch wins, default when none
    function automatic logic [3:0] scan_range(input logic [3:0] sw);
        logic [3:0] code;
        code = sdst_pkg::SDST_RANGE_DEFAULT;
        // Walking down from the last switch lets the lowest pressed one overwrite last
        for (int k = sdst_pkg::SDST_NUM_RANGE_SW - 1; k >= 0; k--) begin
            if (sw[k]) begin
                code = 4'(k + 1);
            end
        end
        return code;
    endfunction : scan_range

    // Function decode including the two combined-switch exceptions
    function automatic logic [3:0] decode_func(input sdst_pkg::sdst_func_sel_t f,
                                               input logic [3:0] sw);
        logic [3:0] code;
        code = sdst_pkg::SDST_FN_NONE;
        if (f.ac_volt) begin
            code = sdst_pkg::SDST_FN_NONE;
        end else if (f.dc_volt) begin
            code = sdst_pkg::SDST_FN_DC_VOLT;
        end else if (f.ac_curr) begin
            code = sdst_pkg::SDST_FN_AC_CURR;
        end else if (f.dc_curr) begin
            code = sdst_pkg::SDST_FN_DC_CURR;
        end else if (f.ohms) begin
            code = sdst_pkg::SDST_FN_OHMS;
            // Only the winning range switch checks its partner
            if (scan_range(sw) == 4'(sdst_pkg::SDST_SW_2K + 1) && sw[sdst_pkg::SDST_SW_20K]) begin
                code = sdst_pkg::SDST_FN_DIODE;
            end else if (scan_range(sw) == 4'(sdst_pkg::SDST_SW_200K + 1)
                         && sw[sdst_pkg::SDST_SW_MEG]) begin
                code = sdst_pkg::SDST_FN_COND;
            end
        end
        return code;
    endfunction : decode_func

    // All panel pins come from outside the clock domain
    sdst_sync #(
        .W(sdst_pkg::SDST_SYNC_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .pin_in({func_sel, buttons, range_sw, comparator_minus_below_plus}),
        .sync_out({fn_s, btn_s, range_s, cmp_s})
    );

    // Edge detector on the synchronised continuity button
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cont_q <= 1'b0;
        end else if (clk_en) begin
            cont_q <= btn_s.continuity;
        end
    end

    assign cont_rise = btn_s.continuity && !cont_q;
    assign vi_sel = fn_s.ac_volt || fn_s.dc_volt || fn_s.ac_curr || fn_s.dc_curr;

    // Mode selection; relative wins if both buttons are held at power-up
    always_comb begin
        next_mode = mode;
        unique case (mode)
            sdst_pkg::SDST_POWERUP: begin
                if (pattern_done) begin
                    if (btn_s.relative) begin
                        next_mode = sdst_pkg::SDST_HOLD_DECODE;
                    end else if (btn_s.continuity && vi_sel) begin
                        next_mode = sdst_pkg::SDST_HOLD_RATIO;
                    end else begin
                        next_mode = sdst_pkg::SDST_NORMAL;
                    end
                end
            end
            sdst_pkg::SDST_NORMAL: begin
                next_mode = sdst_pkg::SDST_NORMAL;
            end
            sdst_pkg::SDST_HOLD_RATIO: begin
                // Wait for the release so the hold is not taken as a cancel
                if (!btn_s.continuity) begin
                    next_mode = sdst_pkg::SDST_RATIO;
                end
            end
            sdst_pkg::SDST_RATIO: begin
                if (cont_rise) begin
                    next_mode = sdst_pkg::SDST_NORMAL;
                end
            end
            sdst_pkg::SDST_HOLD_DECODE: begin
                if (!btn_s.relative) begin
                    next_mode = sdst_pkg::SDST_DECODE;
                end
            end
            sdst_pkg::SDST_DECODE: begin
                next_mode = sdst_pkg::SDST_DECODE;
            end
            default: begin
                next_mode = sdst_pkg::SDST_POWERUP;
            end
        endcase
    end

    // Mode register; only power-on reset leaves the decode test
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mode <= sdst_pkg::SDST_POWERUP;
        end else if (clk_en) begin
            mode <= next_mode;
        end
    end

    // Converter routing follows the mode it is entering, so both change together
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            conv_ctl <= sdst_pkg::SDST_CONV_NORMAL;
        end else if (clk_en) begin
            if (next_mode == sdst_pkg::SDST_RATIO) begin
                conv_ctl <= sdst_pkg::SDST_CONV_RATIO;
            end else begin
                conv_ctl <= sdst_pkg::SDST_CONV_NORMAL;
            end
        end
    end

    // Decode display; blank outside the decode test so normal digits are not overridden
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            disp <= sdst_pkg::SDST_DISP_RESET;
        end else if (clk_en) begin
            if (next_mode == sdst_pkg::SDST_DECODE) begin
                disp.show_decode <= 1'b1;
                disp.digit0 <= scan_range(range_s);
                disp.digit1 <= btn_s;
                disp.digit3 <= decode_func(fn_s, range_s);
                disp.digit3_dash <= fn_s.ac_volt;
                disp.cont_bar <= cmp_s;
            end else begin
                disp <= sdst_pkg::SDST_DISP_RESET;
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_in_decode;
        clk_en && mode == sdst_pkg::SDST_DECODE;
    endsequence

    sequence s_ratio_request;
        clk_en && mode == sdst_pkg::SDST_POWERUP && pattern_done && !btn_s.relative
            && btn_s.continuity;
    endsequence

    decode_stays_a: assert property (mode == sdst_pkg::SDST_DECODE |=>
        mode == sdst_pkg::SDST_DECODE)
        else $error("decode test left");

    ratio_route_a: assert property (mode == sdst_pkg::SDST_RATIO |->
        conv_ctl.integ_src_ref && conv_ctl.read_src_ref)
        else $error("ratio test without reference in both phases");

    normal_route_a: assert property (mode != sdst_pkg::SDST_RATIO |->
        !conv_ctl.integ_src_ref)
        else $error("reference integrated outside ratio test");

    ratio_cancel_a: assert property (clk_en && mode == sdst_pkg::SDST_RATIO
        && cont_rise |=> mode == sdst_pkg::SDST_NORMAL)
        else $error("ratio test not cancelled");

    ratio_entry_a: assert property (s_ratio_request ##0 vi_sel |=>
        mode == sdst_pkg::SDST_HOLD_RATIO ##1 (mode != sdst_pkg::SDST_NORMAL))
        else $error("ratio request lost");

    no_ratio_a: assert property (s_ratio_request ##0 !vi_sel |=>
        mode == sdst_pkg::SDST_NORMAL)
        else $error("ratio test without volts or amps");

    decode_entry_a: assert property (clk_en && mode == sdst_pkg::SDST_HOLD_DECODE
        && !btn_s.relative |=> mode == sdst_pkg::SDST_DECODE ##0 disp.show_decode)
        else $error("decode test not entered");

    range_default_a: assert property (s_in_decode ##0 range_s == 4'h0 |=>
        disp.digit0 == 4'h0)
        else $error("default range wrong");

    range_first_a: assert property (s_in_decode ##0 range_s[0] |=>
        disp.digit0 == 4'h1)
        else $error("lower range switch lost priority");

    range_top_a: assert property (s_in_decode ##0 range_s == 4'h8 |=>
        disp.digit0 == 4'h4)
        else $error("highest range code wrong");

    buttons_a: assert property (s_in_decode |=> disp.digit1 == $past(btn_s))
        else $error("button weights wrong");

    diode_a: assert property (s_in_decode ##0 fn_s == 5'h01
        && range_s[1:0] == 2'h3 |=> disp.digit3 == 4'h7)
        else $error("diode test not decoded");

    cond_a: assert property (s_in_decode ##0 fn_s == 5'h01
        && range_s == 4'hc |=> disp.digit3 == 4'h6)
        else $error("conductance not decoded");

    dc_volt_a: assert property (s_in_decode ##0 fn_s == 5'h08 |=>
        disp.digit3 == 4'h2 && !disp.digit3_dash)
        else $error("dc voltage code wrong");

    cont_bar_a: assert property (s_in_decode |=> disp.cont_bar == $past(cmp_s))
        else $error("continuity bar does not follow comparator");

    // Release of the held continuity button arms the reference routing
    sequence s_ratio_armed;
        clk_en && mode == sdst_pkg::SDST_HOLD_RATIO && !btn_s.continuity;
    endsequence

    // Relative held when the pattern ends; it outranks continuity
    sequence s_decode_request;
        clk_en && mode == sdst_pkg::SDST_POWERUP && pattern_done && btn_s.relative;
    endsequence

    freeze_holds_a: assert property (!clk_en |=> $stable(mode) && $stable(conv_ctl)
        && $stable(disp))
        else $error("state moved while frozen");

    ratio_wait_a: assert property (clk_en && mode == sdst_pkg::SDST_HOLD_RATIO
        && btn_s.continuity |=> mode == sdst_pkg::SDST_HOLD_RATIO
        && conv_ctl == sdst_pkg::SDST_CONV_NORMAL)
        else $error("held button taken as release");

    ratio_start_a: assert property (s_ratio_armed |=>
        mode == sdst_pkg::SDST_RATIO ##0 conv_ctl == sdst_pkg::SDST_CONV_RATIO)
        else $error("ratio test not started on release");

    ratio_keep_a: assert property (mode == sdst_pkg::SDST_RATIO && !cont_rise |=>
        mode == sdst_pkg::SDST_RATIO)
        else $error("ratio test left without a press");

    normal_stays_a: assert property (mode == sdst_pkg::SDST_NORMAL |=>
        mode == sdst_pkg::SDST_NORMAL)
        else $error("normal measurement left");

    decode_request_a: assert property (s_decode_request |=>
        mode == sdst_pkg::SDST_HOLD_DECODE ##1 (mode == sdst_pkg::SDST_HOLD_DECODE
        || mode == sdst_pkg::SDST_DECODE))
        else $error("decode request lost");

    decode_wait_a: assert property (clk_en && mode == sdst_pkg::SDST_HOLD_DECODE
        && btn_s.relative |=> mode == sdst_pkg::SDST_HOLD_DECODE && !disp.show_decode)
        else $error("decode test entered with relative held");

    // Normal digits belong to the measurement path, so nothing may leak out here
    blank_outside_a: assert property (mode != sdst_pkg::SDST_DECODE |->
        disp == sdst_pkg::SDST_DISP_RESET)
        else $error("decode digits shown outside decode test");

    range_second_a: assert property (s_in_decode ##0 range_s[1:0] == 2'h2 |=>
        disp.digit0 == 4'h2)
        else $error("second range code wrong");

    range_third_a: assert property (s_in_decode ##0 range_s[2:0] == 3'h4 |=>
        disp.digit0 == 4'h3)
        else $error("third range code wrong");

    ac_volt_a: assert property (s_in_decode ##0 fn_s.ac_volt |=>
        disp.digit3_dash && disp.digit3 == 4'h0)
        else $error("ac voltage symbol wrong");

    ac_curr_a: assert property (s_in_decode ##0 fn_s == 5'h04 |=>
        disp.digit3 == 4'h3 && !disp.digit3_dash)
        else $error("ac current code wrong");

    dc_curr_a: assert property (s_in_decode ##0 fn_s == 5'h02 |=>
        disp.digit3 == 4'h4)
        else $error("dc current code wrong");

    ohms_plain_a: assert property (s_in_decode ##0 fn_s == 5'h01
        && range_s == 4'h0 |=> disp.digit3 == 4'h5)
        else $error("resistance code wrong");

    // The 20k switch without the 2k switch must not pull in the diode test
    partner_late_a: assert property (s_in_decode ##0 fn_s == 5'h01
        && range_s == 4'h6 |=> disp.digit3 == 4'h5 && disp.digit0 == 4'h2)
        else $error("range partner checked for a losing switch");

endmodule : sdst_top

// ---- sim/sdst_panel.sv ----
`timescale 1ns/1ps
module sdst_panel (
    // Clock
    input wire logic sys_clk,
    // Settings the operator wants
    input wire sdst_pkg::sdst_func_sel_t want_func,
    input wire sdst_pkg::sdst_btn_t want_btn,
    input wire logic [3:0] want_range,
    input wire logic want_below,
    // Front-panel pins
    output sdst_pkg::sdst_func_sel_t func_sel = '0,
    output sdst_pkg::sdst_btn_t buttons = '0,
    output logic [3:0] range_sw = 4'h0,
    output logic comparator_minus_below_plus = 1'b0
);
    // Contacts settle one edge after the operator moves them, so
    // the block never sees a change in the edge that asked for it
    always @(posedge sys_clk) begin
        func_sel <= want_func;
        buttons <= want_btn;
        range_sw <= want_range;
        comparator_minus_below_plus <= want_below;
    end
endmodule : sdst_panel

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic pattern_done = 1'b0;
    logic clk_en = 1'b1;
    sdst_pkg::sdst_func_sel_t wf = '0;
    sdst_pkg::sdst_btn_t wb = '0;
    logic [3:0] wr = 4'h0;
    logic wc = 1'b0;
    sdst_pkg::sdst_func_sel_t func_sel;
    sdst_pkg::sdst_btn_t buttons;
    logic [3:0] range_sw;
    logic below;
    sdst_pkg::sdst_conv_t conv_ctl;
    sdst_pkg::sdst_disp_t disp;
    sdst_pkg::sdst_mode_t mode;
    int n_mismatch = 0;
    int n_compared = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    sdst_panel panel_u (.sys_clk(sys_clk), .want_func(wf), .want_btn(wb),
        .want_range(wr), .want_below(wc), .func_sel(func_sel),
        .buttons(buttons), .range_sw(range_sw),
        .comparator_minus_below_plus(below));

    // Freeze input is driven so that a stalled enable is exercised too
    sdst_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .pattern_done(pattern_done), .func_sel(func_sel), .buttons(buttons),
        .range_sw(range_sw), .comparator_minus_below_plus(below),
        .conv_ctl(conv_ctl), .disp(disp), .mode(mode));

    task automatic chk(input string what, input logic [17:0] seen,
                       input logic [17:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // Power cycle with pins held, then the all-segments pattern ends
    task automatic power_up(input logic [4:0] f, input logic [3:0] b);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        wf <= f;
        wb <= b;
        repeat (16) @(posedge sys_clk);
        #1 chk("reset conv", conv_ctl, sdst_pkg::SDST_CONV_NORMAL);
        chk("reset disp", disp, sdst_pkg::SDST_DISP_RESET);
        chk("reset mode", mode, sdst_pkg::SDST_POWERUP);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
        pattern_done <= 1'b1;
        @(posedge sys_clk);
        pattern_done <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : power_up

    // Move the panel, let it pass the synchronisers, judge the display
    task automatic dchk(input logic [4:0] f, input logic [3:0] b,
                        input logic [3:0] r, input logic c,
                        input logic [17:0] e);
        @(posedge sys_clk);
        wf <= f;
        wb <= b;
        wr <= r;
        wc <= c;
        repeat (7) @(posedge sys_clk);
        #1 chk("disp", disp, e);
        chk("decode mode", mode, sdst_pkg::SDST_DECODE);
    endtask : dchk

    // Wait for synchronised pins, then look at mode and converter
    task automatic settle(input logic [3:0] b, input logic [2:0] m,
                          input logic [1:0] cv);
        @(posedge sys_clk);
        wb <= b;
        repeat (7) @(posedge sys_clk);
        #1 chk("mode", mode, m);
        chk("conv", conv_ctl, cv);
    endtask : settle

    task automatic ratio_test;
        power_up(5'h08, 4'h2);
        #1 chk("hold", mode, sdst_pkg::SDST_HOLD_RATIO);
        settle(4'h2, sdst_pkg::SDST_HOLD_RATIO, 2'h1);
        settle(4'h0, sdst_pkg::SDST_RATIO, 2'h3);
        chk("ratio disp", disp, 18'h0_0000);
        settle(4'h2, sdst_pkg::SDST_NORMAL, 2'h1);
        settle(4'h0, sdst_pkg::SDST_NORMAL, 2'h1);
        power_up(5'h02, 4'h2);
        settle(4'h0, sdst_pkg::SDST_RATIO, 2'h3);
        power_up(5'h01, 4'h2);
        settle(4'h0, sdst_pkg::SDST_NORMAL, 2'h1);
    endtask : ratio_test

    task automatic decode_test;
        power_up(5'h00, 4'h1);
        #1 chk("hold", mode, sdst_pkg::SDST_HOLD_DECODE);
        dchk(5'h08, 4'h0, 4'h0, 1'b0, {1'b1, 12'h002, 2'h0});
        dchk(5'h10, 4'h0, 4'h1, 1'b0, {1'b1, 12'h100, 2'h2});
        dchk(5'h04, 4'h0, 4'h6, 1'b0, {1'b1, 12'h203, 2'h0});
        dchk(5'h02, 4'h0, 4'hc, 1'b0, {1'b1, 12'h304, 2'h0});
        dchk(5'h02, 4'h0, 4'h8, 1'b0, {1'b1, 12'h404, 2'h0});
        dchk(5'h08, 4'h0, 4'hf, 1'b0, {1'b1, 12'h102, 2'h0});
        dchk(5'h01, 4'h0, 4'h5, 1'b0, {1'b1, 12'h105, 2'h0});
        dchk(5'h01, 4'h0, 4'h3, 1'b0, {1'b1, 12'h107, 2'h0});
        dchk(5'h01, 4'h0, 4'hc, 1'b0, {1'b1, 12'h306, 2'h0});
        dchk(5'h01, 4'h0, 4'h0, 1'b0, {1'b1, 12'h005, 2'h0});
        dchk(5'h08, 4'h1, 4'h0, 1'b0, {1'b1, 12'h012, 2'h0});
        dchk(5'h08, 4'h2, 4'h0, 1'b0, {1'b1, 12'h022, 2'h0});
        dchk(5'h08, 4'h4, 4'h0, 1'b0, {1'b1, 12'h042, 2'h0});
        dchk(5'h08, 4'h8, 4'h0, 1'b1, {1'b1, 12'h082, 2'h1});
        dchk(5'h08, 4'hf, 4'h0, 1'b0, {1'b1, 12'h0f2, 2'h0});
        dchk(5'h08, 4'h0, 4'h0, 1'b1, {1'b1, 12'h002, 2'h1});
    endtask : decode_test

    // Pins move while the enable is low; nothing may follow until it returns
    task automatic freeze_test;
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wf <= 5'h01;
        wr <= 4'h6;
        wc <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1 chk("frozen disp", disp, {1'b1, 12'h002, 2'h1});
        chk("frozen mode", mode, sdst_pkg::SDST_DECODE);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk("thawed disp", disp, {1'b1, 12'h205, 2'h0});
    endtask : freeze_test

    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        ratio_test();
        decode_test();
        freeze_test();
        end_of_test();
    end

    // Watchdog, well past the roughly 320 cycles the tests need
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule : testbench
